// ---- logic/hpl_phy_end.sv ----
// Physical-layer end of the host port link with its status indicators.
// Assumes the controller drives the link in step with the port clock
// made here, so link inputs are sampled without synchronisers.
`timescale 1ns/10ps
`default_nettype none
`include "hpl_defs.svh"
module hpl_phy_end #(
  parameter int unsigned ACT_CYCLES = `HPL_ACT_CYC
)(
  input  wire logic         core_clk,             // 10 MHz core clock
  input  wire logic         resetn,               // Async reset
  hpl_link_if.phy           link,                 // Host port link
  input  wire logic         speed_100,            // 100 Mb/s selected
  input  wire logic         link_up,              // Link established
  input  wire logic         wake_mode,            // Wake mode active
  input  wire logic         act_select,           // Nonvolatile select
  input  wire logic         tx_pkt,               // Packet sent pulse
  input  wire logic         rx_pkt,               // Packet seen pulse
  input  wire logic         pkt_broadcast,        // Packet is broadcast
  input  wire logic         pkt_addr_match,       // Own address match
  input  wire logic [2:0]   rx_word,              // Word toward MAC
  input  wire logic         rx_valid,             // rx_word valid
  output logic              rx_ready,             // FIFO accepts
  output logic      [2:0]   tx_word,              // Word from MAC
  output logic              tx_strobe,            // tx_word new
  output logic              word_sync,            // Alignment pulse
  output logic              reset_request,        // Reset held
  output logic              link_indicator_n,     // Link LED
  output logic              activity_indicator_n, // Activity LED
  output logic              speed_indicator_n     // Speed LED
);
  // ***************************************************************
  // Port clock divider
  // ***************************************************************
  logic [`HPL_DIV_W-1:0] half_cnt;
  logic [`HPL_DIV_W-1:0] half_len;
  logic                  hpc;
  logic                  rise_now;

  // Mode change takes effect at the next half period, never a stall
  assign half_len = speed_100 ? `HPL_DIV_W'(`HPL_FAST_HALF)
                              : `HPL_DIV_W'(`HPL_SLOW_HALF);
  assign rise_now = (half_cnt == '0) && !hpc;
  assign link.host_port_clock = hpc;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      half_cnt <= '0;
      hpc      <= 1'b0;
    end
    else if (half_cnt == '0)
    begin
      hpc      <= ~hpc;
      half_cnt <= half_len - 1'b1;
    end
    else
    begin
      half_cnt <= half_cnt - 1'b1;
    end
  end

  // ***************************************************************
  // Reset and synchronise line
  // ***************************************************************
  logic [1:0] line_cnt;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      line_cnt <= 2'h0;
    else if (rise_now)
    begin
      if (!link.reset_sync_line)
        line_cnt <= 2'h0;
      else if (line_cnt != `HPL_RST_SAMPLES)
        line_cnt <= line_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reset_request <= 1'b0;
    else if (rise_now)
      reset_request <= link.reset_sync_line && (line_cnt != 2'h0);
  end

  // A lone sample followed by a low one is a sync, not a reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      word_sync <= 1'b0;
    else
      word_sync <= rise_now && !link.reset_sync_line
                   && (line_cnt == 2'h1);
  end

  // ***************************************************************
  // Transmit bits from the controller
  // ***************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_word   <= `HPL_IDLE_BITS;
      tx_strobe <= 1'b0;
    end
    else
    begin
      tx_strobe <= rise_now && !reset_request;
      if (rise_now)
        tx_word <= link.port_tx_bits;
    end
  end

  // ***************************************************************
  // Receive path through the FIFO
  // ***************************************************************
  hpl_pkg::hpl_word_t fifo_data;
  logic               fifo_valid;
  logic               fifo_take;
  hpl_pkg::hpl_word_t rx_bits;

  // One word leaves per port clock period; the FIFO fills otherwise
  assign fifo_take = rise_now && !reset_request;
  assign link.port_rx_bits = rx_bits;

  hpl_fifo #(
    .WIDTH (`HPL_WORD_W),
    .DEPTH (`HPL_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .flush     (reset_request),
    .in_data   (rx_word),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rx_bits <= `HPL_IDLE_BITS;
    else if (rise_now)
      rx_bits <= fifo_take && fifo_valid ? fifo_data
                                          : `HPL_IDLE_BITS;
  end

  // ***************************************************************
  // Status indicators
  // ***************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_indicator_n  <= 1'b1;
      speed_indicator_n <= 1'b1;
    end
    else
    begin
      link_indicator_n  <= !link_up;
      speed_indicator_n <= !speed_100;
    end
  end

  logic                  act_event;
  logic                  act_on;
  logic                  act_pend;
  logic [`HPL_CNT_W-1:0] act_cnt;

  assign act_event = (tx_pkt || rx_pkt)
                     && (!wake_mode || pkt_addr_match
                         || (!act_select && pkt_broadcast));

  // Fixed on and off phases: heavy load gives a steady flicker,
  // light load one blink for a lone packet, two for a short burst
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      act_on   <= 1'b0;
      act_pend <= 1'b0;
      act_cnt  <= '0;
    end
    else if (act_cnt != '0)
    begin
      act_cnt  <= act_cnt - 1'b1;
      act_pend <= act_pend || act_event;
    end
    else if (act_on)
    begin
      act_on   <= 1'b0;
      act_cnt  <= `HPL_CNT_W'(ACT_CYCLES - 1);
      act_pend <= act_pend || act_event;
    end
    else if (act_pend || act_event)
    begin
      act_on   <= 1'b1;
      act_cnt  <= `HPL_CNT_W'(ACT_CYCLES - 1);
      act_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      activity_indicator_n <= 1'b1;
    else
      activity_indicator_n <= !act_on;
  end
endmodule
`default_nettype wire

// ---- logic/hpl_defs.svh ----
// Constants for the host port link: timing, widths, encodings.
// Assumes a 10 MHz core clock on both ends of the link.
`ifndef HPL_DEFS_SVH
`define HPL_DEFS_SVH
`define HPL_CORE_NS     100
`define HPL_CLK_SCALE   20
`define HPL_FAST_NS     20
`define HPL_SLOW_NS     200
`define HPL_FAST_HALF   (((`HPL_FAST_NS*`HPL_CLK_SCALE)/2)/`HPL_CORE_NS)
`define HPL_SLOW_HALF   (((`HPL_SLOW_NS*`HPL_CLK_SCALE)/2)/`HPL_CORE_NS)
`define HPL_DIV_W       5
`define HPL_RESET_US    500
`define HPL_RESET_CYC   ((`HPL_RESET_US*1000+`HPL_CORE_NS-1)/`HPL_CORE_NS)
`define HPL_ACT_US      10000
`define HPL_ACT_CYC     ((`HPL_ACT_US*1000)/`HPL_CORE_NS)
`define HPL_CNT_W       32
`define HPL_RST_SAMPLES 2'h2
`define HPL_WORD_W      3
`define HPL_FIFO_DEPTH  32
`define HPL_IDLE_BITS   3'h0
`endif

// ---- logic/hpl_pkg.sv ----
// Types shared by both ends of the host port link.
// Assumes hpl_defs.svh is on the include path.
`default_nettype none
package hpl_pkg;
  typedef logic [2:0] hpl_word_t;
  typedef enum logic [2:0]
  {
    HPL_LINE_IDLE  = 3'h1,
    HPL_LINE_SYNC  = 3'h2,
    HPL_LINE_RESET = 3'h4
  } hpl_line_state_t;
endpackage
`default_nettype wire

// ---- logic/hpl_link_if.sv ----
// Host port link between the physical-layer end and the controller.
// Assumes the bench joins both ends; no clocking block.
`timescale 1ns/10ps
`default_nettype none
interface hpl_link_if;
  logic             host_port_clock;
  logic             reset_sync_line;
  hpl_pkg::hpl_word_t port_tx_bits;
  hpl_pkg::hpl_word_t port_rx_bits;
  modport phy
  (
    output host_port_clock,
    output port_rx_bits,
    input  reset_sync_line,
    input  port_tx_bits
  );
  modport mac
  (
    input  host_port_clock,
    input  port_rx_bits,
    output reset_sync_line,
    output port_tx_bits
  );
endinterface
`default_nettype wire

// ---- logic/hpl_fifo.sv ----
// Word FIFO with registered full and empty flags.
// Assumes both sides on core_clk; flush drops every stored word.
`timescale 1ns/10ps
`default_nettype none
`include "hpl_defs.svh"
module hpl_fifo #(
  parameter int unsigned WIDTH = `HPL_WORD_W,
  parameter int unsigned DEPTH = `HPL_FIFO_DEPTH
)(
  input  wire logic             core_clk,  // Core clock
  input  wire logic             resetn,    // Async reset
  input  wire logic             flush,     // Drop contents
  input  wire logic [WIDTH-1:0] in_data,   // Fill data
  input  wire logic             in_valid,  // Fill valid
  output logic                  in_ready,  // Not full
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Drain accept
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else if (flush)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule
`default_nettype wire

// ---- logic/hpl_mac_end.sv ----
// Controller end of the host port link.
// Assumes the port clock and receive bits arrive from outside the
// core clock domain; both pass two flip-flops before use.
`timescale 1ns/10ps
`default_nettype none
`include "hpl_defs.svh"
module hpl_mac_end #(
  parameter int unsigned RESET_CYCLES = `HPL_RESET_CYC
)(
  input  wire logic       core_clk,  // 10 MHz core clock
  input  wire logic       resetn,    // Async reset
  hpl_link_if.mac         link,      // Host port link
  input  wire logic [2:0] tx_word,   // Word toward PHY
  input  wire logic       tx_valid,  // tx_word valid
  output logic            tx_ready,  // Holding slot free
  input  wire logic       sync_req,  // Request sync pulse
  input  wire logic       reset_req, // Request PHY reset
  output logic      [2:0] rx_word,   // Word from PHY
  output logic            rx_strobe, // rx_word new
  output logic            line_busy  // Sync or reset running
);
  // ***************************************************************
  // Input synchronisers and edge find
  // ***************************************************************
  logic               clk_s1;
  logic               clk_s2;
  logic               clk_s3;
  hpl_pkg::hpl_word_t rx_s1;
  hpl_pkg::hpl_word_t rx_s2;
  logic               rise;

  assign rise = clk_s2 && !clk_s3;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      rx_s1  <= `HPL_IDLE_BITS;
      rx_s2  <= `HPL_IDLE_BITS;
    end
    else
    begin
      clk_s1 <= link.host_port_clock;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      rx_s1  <= link.port_rx_bits;
      rx_s2  <= rx_s1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_word   <= `HPL_IDLE_BITS;
      rx_strobe <= 1'b0;
    end
    else
    begin
      rx_strobe <= rise;
      if (rise)
        rx_word <= rx_s2;
    end
  end

  // ***************************************************************
  // Transmit holding slot
  // ***************************************************************
  hpl_pkg::hpl_word_t tx_hold;
  logic               hold_full;
  logic               next_full;
  hpl_pkg::hpl_word_t tx_bits;
  hpl_pkg::hpl_line_state_t state;

  assign link.port_tx_bits = tx_bits;

  always_comb
  begin
    next_full = hold_full;
    if (rise && state != hpl_pkg::HPL_LINE_RESET)
      next_full = 1'b0;
    if (tx_valid && tx_ready)
      next_full = 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_full <= 1'b0;
      tx_ready  <= 1'b0;
      tx_hold   <= `HPL_IDLE_BITS;
      tx_bits   <= `HPL_IDLE_BITS;
    end
    else
    begin
      hold_full <= next_full;
      tx_ready  <= !next_full;
      if (tx_valid && tx_ready)
        tx_hold <= tx_word;
      // Bits change three core cycles after the port clock rises, on the synchronised rise
      if (rise)
        tx_bits <= hold_full && state != hpl_pkg::HPL_LINE_RESET
                   ? tx_hold : `HPL_IDLE_BITS;
    end
  end

  // ***************************************************************
  // Reset and synchronise line
  // ***************************************************************
  logic                  sync_pend;
  logic                  reset_pend;
  logic [`HPL_CNT_W-1:0] hold_cnt;
  logic                  line;

  assign link.reset_sync_line = line;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state      <= hpl_pkg::HPL_LINE_IDLE;
      line       <= 1'b0;
      line_busy  <= 1'b0;
      sync_pend  <= 1'b0;
      reset_pend <= 1'b0;
      hold_cnt   <= '0;
    end
    else
    begin
      // A new request wins over the clear of the same cycle
      if (sync_req)
        sync_pend <= 1'b1;
      if (reset_req)
        reset_pend <= 1'b1;
      if (hold_cnt != '0)
        hold_cnt <= hold_cnt - 1'b1;
      case (state)
        hpl_pkg::HPL_LINE_IDLE:
        begin
          line_busy <= reset_pend || sync_pend;
          if (rise && reset_pend && !reset_req)
          begin
            reset_pend <= 1'b0;
            line       <= 1'b1;
            hold_cnt   <= `HPL_CNT_W'(RESET_CYCLES);
            state      <= hpl_pkg::HPL_LINE_RESET;
          end
          else if (rise && sync_pend && !sync_req)
          begin
            sync_pend <= 1'b0;
            line      <= 1'b1;
            state     <= hpl_pkg::HPL_LINE_SYNC;
          end
        end
        hpl_pkg::HPL_LINE_SYNC:
        begin
          line_busy <= 1'b1;
          if (rise)
          begin
            line  <= 1'b0;
            state <= hpl_pkg::HPL_LINE_IDLE;
          end
        end
        hpl_pkg::HPL_LINE_RESET:
        begin
          line_busy <= 1'b1;
          if (rise && hold_cnt == '0)
          begin
            line  <= 1'b0;
            state <= hpl_pkg::HPL_LINE_IDLE;
          end
        end
        default:
        begin
          line  <= 1'b0;
          state <= hpl_pkg::HPL_LINE_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/hpl_link_properties.sv ----
// Wire-level properties of the host port link between the two ends.
// Assumes it sits beside the link interface; one core clock domain.
`timescale 1ns/10ps
`default_nettype none
module hpl_link_properties #(
  parameter int unsigned RESET_CYCLES = 5000
)(
  input wire logic               core_clk,        // Core clock
  input wire logic               resetn,          // Async reset
  input wire logic               host_port_clock, // Port clock
  input wire logic               reset_sync_line, // Reset or sync
  input wire hpl_pkg::hpl_word_t port_tx_bits,    // Toward phy end
  input wire hpl_pkg::hpl_word_t port_rx_bits     // Toward mac end
);
  // ****************
  // Helper counters
  // ****************
  logic        clk_q;
  logic        armed;
  logic        rise;
  logic [7:0]  run;
  logic [7:0]  age;
  logic [7:0]  hits;
  logic [31:0] line_run;

  assign rise = host_port_clock && !clk_q;

  // First half period after reset is not judged: its start is unknown
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      clk_q <= 1'b0;
      armed <= 1'b0;
      run   <= 8'h00;
      age   <= 8'hff;
    end
    else
    begin
      clk_q <= host_port_clock;
      if (host_port_clock != clk_q)
      begin
        armed <= 1'b1;
        run   <= 8'h01;
      end
      else if (run != 8'hff)
        run <= run + 8'h01;
      if (rise)
        age <= 8'h00;
      else if (age != 8'hff)
        age <= age + 8'h01;
    end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      hits     <= 8'h00;
      line_run <= 32'h0;
    end
    else
    begin
      line_run <= reset_sync_line ? line_run + 32'h1 : 32'h0;
      if (rise)
        hits <= reset_sync_line ? hits + 8'h01 : 8'h00;
    end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_half_period_len:
  assert property (armed && host_port_clock != clk_q |->
                   (run == 8'd2 || run == 8'd20))
    else $error("port clock half period is neither 2 nor 20 cycles");
  chk_clock_never_stops:
  assert property (armed |-> run <= 8'd20)
    else $error("port clock stood still too long");
  chk_line_pulse_len:
  assert property ($fell(reset_sync_line) |-> line_run == 32'd4 ||
                   line_run == 32'd40 || line_run >= RESET_CYCLES)
    else $error("line pulse neither one period nor a full reset");
  chk_tx_after_rise:
  assert property ($changed(port_tx_bits) |-> age < 8'd5)
    else $error("transmit bits changed away from a port clock rise");
  chk_line_after_rise:
  assert property ($changed(reset_sync_line) |-> age < 8'd5)
    else $error("line changed away from a port clock rise");
  chk_rx_on_rise:
  assert property ($changed(port_rx_bits) |-> $rose(host_port_clock))
    else $error("receive bits changed without a port clock rise");
  chk_rx_idle_reset:
  assert property (rise && hits >= 8'd3 |-> port_rx_bits == 3'h0)
    else $error("receive bits not idle while reset is held");
  chk_tx_idle_reset:
  assert property (reset_sync_line && line_run > 32'd44 |->
                   port_tx_bits == 3'h0)
    else $error("transmit bits not idle while reset is held");

  cov_sync_fast: cover property ($fell(reset_sync_line) && line_run == 4);
  cov_sync_slow: cover property ($fell(reset_sync_line) && line_run == 40);
  cov_reset_long: cover property ($fell(reset_sync_line) &&
                                  line_run >= RESET_CYCLES);
endmodule
`default_nettype wire

// ---- tb/test_phy_host_port_and_status_leds.sv ----
// Bench joining both ends of the host port link through one interface.
// Assumes the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_phy_host_port_and_status_leds;
  // ****************
  // Set-up
  // ****************
  // Short counts keep the run brief; expectations derive from them
  localparam int ACT   = 4;
  localparam int RST   = 60;
  localparam int LIMIT = 12000;

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic speed_100 = 1'b1, link_up = 1'b0;
  logic wake_mode = 1'b0, act_select = 1'b0, tx_pkt = 1'b0, rx_pkt = 1'b0;
  logic pkt_broadcast = 1'b0, pkt_addr_match = 1'b0;
  logic rx_valid = 1'b0, tx_valid = 1'b0, sync_req = 1'b0, reset_req = 1'b0;
  logic [2:0] rx_word = 3'h0, tx_word = 3'h0;
  logic rx_ready, tx_strobe, word_sync, reset_request, tx_ready, rx_strobe;
  logic link_indicator_n, activity_indicator_n, speed_indicator_n;
  logic line_busy;
  logic [2:0] phy_tx_word, mac_rx_word;
  logic [2:0] exp_tx[$], got_tx[$], exp_rx[$], got_rx[$];
  int err_total = 0, checks_done = 0, cycles = 0;
  int sync_cnt, rst_cnt, low_cnt, full_seen;
  integer seed;

  hpl_link_if link();
  hpl_phy_end #(.ACT_CYCLES(ACT)) i_hpl_phy_end (
    .core_clk(core_clk), .resetn(resetn), .link(link),
    .speed_100(speed_100), .link_up(link_up), .wake_mode(wake_mode),
    .act_select(act_select), .tx_pkt(tx_pkt), .rx_pkt(rx_pkt),
    .pkt_broadcast(pkt_broadcast), .pkt_addr_match(pkt_addr_match),
    .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_word(phy_tx_word), .tx_strobe(tx_strobe), .word_sync(word_sync),
    .reset_request(reset_request), .link_indicator_n(link_indicator_n),
    .activity_indicator_n(activity_indicator_n),
    .speed_indicator_n(speed_indicator_n));
  hpl_mac_end #(.RESET_CYCLES(RST)) i_hpl_mac_end (
    .core_clk(core_clk), .resetn(resetn), .link(link),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .sync_req(sync_req), .reset_req(reset_req), .rx_word(mac_rx_word),
    .rx_strobe(rx_strobe), .line_busy(line_busy));
  hpl_link_properties #(.RESET_CYCLES(RST)) i_hpl_link_properties (
    .core_clk(core_clk), .resetn(resetn),
    .host_port_clock(link.host_port_clock),
    .reset_sync_line(link.reset_sync_line),
    .port_tx_bits(link.port_tx_bits), .port_rx_bits(link.port_rx_bits));

  always #50 core_clk = ~core_clk;

  // ****************
  // Helpers
  // ****************
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Idle words are zero, so traffic uses nonzero words, each unlike the one before
  function automatic logic [2:0] rnd_word(input logic [2:0] prev);
    logic [2:0] w;
    w = prev;
    while (w == prev || w == 3'h0)
      w = 3'($random(seed));
    return w;
  endfunction

  function automatic logic exp_blink(input logic [3:0] m);
    return !m[3] || m[0] || (m[1] && !m[2]);
  endfunction

  // Holds the word until ready is seen high at an edge
  task automatic send(input logic to_phy, input logic [2:0] w);
    int n;
    n = 0;
    if (to_phy)
    begin
      rx_word <= w;
      rx_valid <= 1'b1;
    end
    else
    begin
      tx_word <= w;
      tx_valid <= 1'b1;
    end
    @(posedge core_clk);
    while ((to_phy ? rx_ready : tx_ready) !== 1'b1 && n < 2000)
    begin
      if (to_phy)
        full_seen++;
      @(posedge core_clk);
      n++;
    end
    if (to_phy)
      rx_valid <= 1'b0;
    else
      tx_valid <= 1'b0;
    if (to_phy)
      exp_rx.push_back(w);
    else
      exp_tx.push_back(w);
    @(posedge core_clk);
  endtask

  task automatic cmp_q(input string what, ref logic [2:0] e[$],
                       ref logic [2:0] g[$]);
    check(what, e.size(), g.size());
    foreach (e[i])
      if (i < g.size())
        check(what, e[i], g[i]);
    e.delete();
    g.delete();
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (tx_strobe === 1'b1 && phy_tx_word !== 3'h0)
      got_tx.push_back(phy_tx_word);
    if (rx_strobe === 1'b1 && mac_rx_word !== 3'h0)
      got_rx.push_back(mac_rx_word);
    if (word_sync === 1'b1)
      sync_cnt++;
    if (reset_request === 1'b1)
      rst_cnt++;
    if (activity_indicator_n === 1'b0)
      low_cnt++;
    if (cycles == LIMIT)
    begin
      err_total++;
      end_of_test;
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    logic [2:0] wt;
    logic [2:0] wr;
    logic       b;
    seed = 32'hb151dab9;
    wt = 3'h0;
    wr = 3'h0;
    tick(4);
    check("leds in reset", 3'h7, {link_indicator_n, activity_indicator_n,
          speed_indicator_n});
    tick(4);
    resetn <= 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++)
    begin
      link_up <= i[0];
      speed_100 <= i[1];
      tick(3);
      check("link led", !i[0], link_indicator_n);
      check("speed led", !i[1], speed_indicator_n);
    end
    $display("test leds done, errors %0d", err_total);
    for (int s = 1; s >= 0; s--)
    begin
      speed_100 <= s[0];
      tick(50);
      full_seen = 0;
      fork
        for (int j = 0; j < 36; j++)
        begin
          wt = rnd_word(wt);
          send(1'b0, wt);
        end
        for (int j = 0; j < 36; j++)
        begin
          wr = rnd_word(wr);
          send(1'b1, wr);
        end
      join
      tick(s ? 200 : 1500);
      cmp_q("phy tx word", exp_tx, got_tx);
      cmp_q("mac rx word", exp_rx, got_rx);
      if (s == 0)
        check("fifo refused", 1, full_seen > 0);
    end
    $display("test traffic done, errors %0d", err_total);
    for (int k = 0; k < 4; k++)
    begin
      speed_100 <= k[0];
      tick(50);
      sync_cnt = 0;
      rst_cnt = 0;
      if (k[1])
        reset_req <= 1'b1;
      else
        sync_req <= 1'b1;
      tick(1);
      reset_req <= 1'b0;
      sync_req <= 1'b0;
      // Words offered while reset is held must wait, then pass intact
      while (k[1] && reset_request !== 1'b1)
        tick(1);
      if (k[1])
      begin
        wt = rnd_word(wt);
        send(1'b0, wt);
        wr = rnd_word(wr);
        send(1'b1, wr);
      end
      tick(400);
      check("sync pulses", !k[1], sync_cnt);
      check("reset seen", k[1], rst_cnt > 0);
      check("reset request", 1'b0, reset_request);
      check("line busy", 1'b0, line_busy);
      if (k[1])
      begin
        cmp_q("tx after reset", exp_tx, got_tx);
        cmp_q("rx after reset", exp_rx, got_rx);
      end
    end
    $display("test line done, errors %0d", err_total);
    for (int i = 0; i < 16; i++)
    begin
      wake_mode <= i[3];
      act_select <= i[2];
      pkt_broadcast <= i[1];
      pkt_addr_match <= i[0];
      b = 1'($random(seed));
      tx_pkt <= b;
      rx_pkt <= !b;
      tick(1);
      tx_pkt <= 1'b0;
      rx_pkt <= 1'b0;
      low_cnt = 0;
      tick(3 * ACT + 6);
      check("activity cycles", exp_blink(i[3:0]) ? ACT : 0,
            low_cnt);
    end
    wake_mode <= 1'b0;
    low_cnt = 0;
    tx_pkt <= 1'b1;
    tick(1);
    tx_pkt <= 1'b0;
    rx_pkt <= 1'b1;
    tick(1);
    rx_pkt <= 1'b0;
    tick(5 * ACT + 8);
    check("burst activity", 2 * ACT, low_cnt);
    $display("test activity done, errors %0d", err_total);
    end_of_test;
  end
endmodule
`default_nettype wire
